//--- mphs_top.sv
/*
  Mesh packet header and status block: sequence number, transit delay timer,
  hop count, link admission, status interrogation events, route trace, stream
  segment index, nearest beacon tracking and competing-gateway checking.
  Assumes a single AHB-Lite master; the radio and UART sit outside and talk to
  this block through the registers.
*/
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
// Operation
// - Keep 16-bit sequence number per created packet
// - Sequence wraps at 64k, clears on reset
// - Reset notice after power-on, force reset, set-config
// - 16-bit delay timer cleared at creation, runs
// - Timer ticks every 10ms or 2560ms
// - Delay timer saturates at maximum
// - Forwarding adds exactly one hop
// - New link only if strength within threshold
// - Status report on command or interval
// - Next-receiver query returns preferred receiver
// - Tag query answered only by gateway
// - Config read dumps first 120 bytes
// - Route trace adds 5-byte hops, truncates
// - Route trace valid only unencrypted
// - Segment index 0 on serial time-out
// - Stream segments count 1..255, wrap, end 0
// - Beacon role defaults disabled
// - Router keeps strongest beacon identifier
// - Event packets carry nearest beacon identifier
// - Gateway checks competing activity before forming
// - Segment index sits at byte 18
`timescale 1ns/1ps
module mphs_top #(
  parameter int unsigned TICK_FAST = mphs_pkg::TICK_FAST_CYCLES,
  parameter int unsigned TICK_SLOW = mphs_pkg::TICK_SLOW_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Event strobe toward the radio side
  output logic             event_valid,
  output logic      [7:0]  event_detail
);
  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] ctrl, thresh, next_rx, net_tag;
  logic [15:0] seq_num, delay_timer;
  logic [7:0]  hop_count, seg_index, beacon_strength, route_bytes;
  logic [31:0] beacon_id, report_addr;
  logic        link_ok, beacon_valid, route_valid, route_full;
  logic        activity_seen, mesh_formed, status_timer_due;
  logic [31:0] tick_cnt;
  logic [7:0]  interval_cnt;
  logic        tick;
  wire logic   acc = hsel & hready & htrans[1];
  wire logic [31:0] cmd = (wr_pend && wr_addr == mphs_pkg::OFS_CMD) ? hwdata : 32'h0;

  // Word write decode used by every register except the command strobes
  function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = pend && (a == ofs);
  endfunction

  // Writes land one cycle after the address phase; reads answer in the data phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0;
    end else if (clk_en) begin
      wr_pend <= acc & hwrite;
      wr_addr <= {haddr[7:2], 2'b00};
      if (acc && !hwrite) begin
        case ({haddr[7:2], 2'b00})
          mphs_pkg::OFS_CTRL:        hrdata <= ctrl;
          mphs_pkg::OFS_THRESH:      hrdata <= thresh;
          mphs_pkg::OFS_NEXT_RX:     hrdata <= next_rx;
          mphs_pkg::OFS_NET_TAG:     hrdata <= net_tag;
          mphs_pkg::OFS_LINK:        hrdata <= {31'h0, link_ok};
          mphs_pkg::OFS_BEACON:      hrdata <= beacon_id;
          mphs_pkg::OFS_HDR_SEQ:     hrdata <= {delay_timer, seq_num};
          mphs_pkg::OFS_FWD:         hrdata <= {24'h0, hop_count};
          mphs_pkg::OFS_SERIAL:      hrdata <= {16'h0, mphs_pkg::SEG_BYTE_POS, seg_index};
          mphs_pkg::OFS_REPORT:      hrdata <= {24'h0, event_detail};
          mphs_pkg::OFS_REPORT_ADDR: hrdata <= report_addr;
          mphs_pkg::OFS_STATUS:      hrdata <= {27'h0, route_valid, activity_seen, mesh_formed,
                                                beacon_valid, route_full};
          mphs_pkg::OFS_ROUTE:       hrdata <= {24'h0, route_bytes};
          default:                   hrdata <= 32'h0;
        endcase
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Beacon role and all other settings come out of reset cleared
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl    <= mphs_pkg::CTRL_RESET;
      thresh  <= 32'h0;
      next_rx <= 32'h0;
      net_tag <= 32'h0;
    end else if (clk_en) begin
      if (wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_CTRL))    ctrl    <= hwdata;
      if (wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_THRESH))  thresh  <= hwdata;
      if (wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_NEXT_RX)) next_rx <= hwdata;
      if (wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_NET_TAG)) net_tag <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // Header fields
  // ----------------------------------------------------------------
  // Natural 16-bit wrap gives the return to zero after 64k packets
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seq_num <= 16'h0;
    end else if (clk_en && cmd[mphs_pkg::CMD_NEW_PACKET]) begin
      seq_num <= seq_num + 16'h1;
    end
  end

  // Tick prescaler; 32 bits so the slow base count is never truncated
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else if (clk_en) begin
      tick <= 1'b0;
      if (cmd[mphs_pkg::CMD_NEW_PACKET]) begin
        tick_cnt <= 32'h0;
      end else if (tick_cnt >= (ctrl[mphs_pkg::CTRL_TICK_SEL] ? 32'(TICK_SLOW - 1) : 32'(TICK_FAST - 1))) begin
        tick_cnt <= 32'h0;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
    end
  end

  // Delay timer runs from creation until handed to the host, then freezes
  logic timer_run;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      delay_timer <= 16'h0;
      timer_run   <= 1'b0;
    end else if (clk_en) begin
      if (cmd[mphs_pkg::CMD_NEW_PACKET]) begin
        delay_timer <= 16'h0;
        timer_run   <= 1'b1;
      end else if (cmd[mphs_pkg::CMD_DELIVER]) begin
        timer_run <= 1'b0;
      end else if (timer_run && tick && delay_timer != 16'hffff) begin
        delay_timer <= delay_timer + 16'h1;
      end
    end
  end

  // Forward hop: software writes the received count, reads it back plus one
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hop_count <= 8'h0;
    end else if (clk_en && wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_FWD)) begin
      hop_count <= hwdata[7:0] + 8'h1;
    end
  end

  // Link admission: lower strength value is the better link
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      link_ok <= 1'b0;
    end else if (clk_en && wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_LINK)) begin
      link_ok <= hwdata[7:0] <= thresh[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Nearest beacon
  // ----------------------------------------------------------------
  // Write carries {strength[7:0], id[23:0]}; only strictly stronger replaces
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      beacon_id       <= 32'h0;
      beacon_strength <= 8'hff;
      beacon_valid    <= 1'b0;
    end else if (clk_en && wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_BEACON) && !ctrl[mphs_pkg::CTRL_GATEWAY]) begin
      if (!beacon_valid || hwdata[31:24] < beacon_strength) begin
        beacon_id       <= {8'h0, hwdata[23:0]};
        beacon_strength <= hwdata[31:24];
        beacon_valid    <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial stream segment index
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seg_index <= 8'h0;
    end else if (clk_en) begin
      if (cmd[mphs_pkg::CMD_SER_TIMEOUT] || cmd[mphs_pkg::CMD_SER_LAST]) begin
        seg_index <= 8'h0;
      end else if (cmd[mphs_pkg::CMD_SER_STREAM]) begin
        seg_index <= (seg_index == mphs_pkg::SEG_MAX) ? 8'h1 : seg_index + 8'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Route trace and competing gateway
  // ----------------------------------------------------------------
  // Each hop write appends one 5-byte entry; full payload truncates
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      route_bytes <= 8'h0;
      route_full  <= 1'b0;
      route_valid <= 1'b0;
    end else if (clk_en) begin
      if (cmd[mphs_pkg::CMD_ROUTE_START]) begin
        route_bytes <= 8'h0;
        route_full  <= 1'b0;
        route_valid <= !ctrl[mphs_pkg::CTRL_ENCRYPTED];
      end else if (wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_ROUTE)) begin
        if (route_bytes + mphs_pkg::ROUTE_ENTRY_B <= mphs_pkg::ROUTE_MAX_B) begin
          route_bytes <= route_bytes + mphs_pkg::ROUTE_ENTRY_B;
        end else begin
          route_full <= 1'b1;
        end
      end
    end
  end

  // Activity sets, the set wins over a same-cycle form request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      activity_seen <= 1'b0;
      mesh_formed   <= 1'b0;
    end else if (clk_en) begin
      if (cmd[mphs_pkg::CMD_ACTIVITY] && ctrl[mphs_pkg::CTRL_BUSY_CHECK]) begin
        activity_seen <= 1'b1;
      end
      if (cmd[mphs_pkg::CMD_FORM_MESH] && ctrl[mphs_pkg::CTRL_GATEWAY]) begin
        mesh_formed <= !(ctrl[mphs_pkg::CTRL_BUSY_CHECK] && ctrl[mphs_pkg::CTRL_BUSY_HOLD]
                         && (activity_seen || cmd[mphs_pkg::CMD_ACTIVITY]));
      end
    end
  end

  // ----------------------------------------------------------------
  // Status report interval
  // ----------------------------------------------------------------
  // Interval in thresh[15:8] counted in delay timer ticks; zero disables
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      interval_cnt     <= 8'h0;
      status_timer_due <= 1'b0;
    end else if (clk_en) begin
      status_timer_due <= 1'b0;
      if (thresh[15:8] == 8'h0) begin
        interval_cnt <= 8'h0;
      end else if (tick) begin
        if (interval_cnt + 8'h1 >= thresh[15:8]) begin
          interval_cnt     <= 8'h0;
          status_timer_due <= 1'b1;
        end else begin
          interval_cnt <= interval_cnt + 8'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event generation
  // ----------------------------------------------------------------
  // Power-on notice is pending from reset; priority resets, queries, reports
  logic reset_pend;
  logic [31:0] sel_addr;
  always_comb begin
    case (ctrl[mphs_pkg::CTRL_ADDR_SEL +: 3])
      mphs_pkg::ADDR_SEL_BEACON: sel_addr = beacon_id;
      mphs_pkg::ADDR_SEL_NEXT:   sel_addr = next_rx;
      default:                   sel_addr = ctrl[mphs_pkg::CTRL_GATEWAY] ? 32'h0 : beacon_id;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reset_pend   <= 1'b1;
      event_valid  <= 1'b0;
      event_detail <= 8'h0;
      report_addr  <= 32'h0;
    end else if (clk_en) begin
      event_valid <= 1'b0;
      if (cmd[mphs_pkg::CMD_FORCE_RESET] || cmd[mphs_pkg::CMD_SET_CONFIG]) begin
        reset_pend <= 1'b1;
      end else if (reset_pend) begin
        reset_pend   <= 1'b0;
        event_valid  <= 1'b1;
        event_detail <= mphs_pkg::DET_RESET;
        report_addr  <= 32'h0;
      end else if (cmd[mphs_pkg::CMD_NEXT_RX_Q]) begin
        event_valid  <= 1'b1;
        event_detail <= mphs_pkg::DET_NEXT_RX;
        report_addr  <= next_rx;
      end else if (cmd[mphs_pkg::CMD_TAG_Q] && ctrl[mphs_pkg::CTRL_GATEWAY]) begin
        event_valid  <= 1'b1;
        event_detail <= mphs_pkg::DET_NET_TAG;
        report_addr  <= net_tag;
      end else if (cmd[mphs_pkg::CMD_CFG_DUMP]) begin
        event_valid  <= 1'b1;
        event_detail <= mphs_pkg::DET_CFG_DUMP;
        report_addr  <= {24'h0, mphs_pkg::CFG_DUMP_BYTES};
      end else if (cmd[mphs_pkg::CMD_GET_STATUS] || status_timer_due) begin
        event_valid  <= 1'b1;
        event_detail <= mphs_pkg::DET_STATUS;
        report_addr  <= sel_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_seq_step: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && cmd[mphs_pkg::CMD_NEW_PACKET] |=> seq_num == $past(seq_num) + 16'h1)
    else $error("sequence number did not step");
  a_seq_reset: assert property (@(posedge clk_sys) $rose(rstn) |-> seq_num == 16'h0)
    else $error("sequence not zero after reset");
  a_timer_sat: assert property (@(posedge clk_sys) disable iff (!rstn)
    delay_timer == 16'hffff && !(clk_en && cmd[mphs_pkg::CMD_NEW_PACKET]) |=> delay_timer == 16'hffff)
    else $error("delay timer wrapped");
  a_timer_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && cmd[mphs_pkg::CMD_NEW_PACKET] |=> delay_timer == 16'h0 && timer_run)
    else $error("delay timer not cleared on creation");
  a_hop_inc: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_FWD) |=> hop_count == $past(hwdata[7:0]) + 8'h1)
    else $error("hop count not one more");
  a_link_admit: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && wr_hit(wr_pend, wr_addr, mphs_pkg::OFS_LINK) && hwdata[7:0] > thresh[7:0] |=> !link_ok)
    else $error("weak link admitted");
  a_tag_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    event_valid && event_detail == mphs_pkg::DET_NET_TAG |-> ctrl[mphs_pkg::CTRL_GATEWAY])
    else $error("tag answered by non-gateway");
  a_seg_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && cmd[mphs_pkg::CMD_SER_STREAM] && !cmd[mphs_pkg::CMD_SER_TIMEOUT] && !cmd[mphs_pkg::CMD_SER_LAST]
    && seg_index == 8'hff |=> seg_index == 8'h1)
    else $error("segment index did not wrap to one");
  a_route_cap: assert property (@(posedge clk_sys) disable iff (!rstn)
    route_bytes <= mphs_pkg::ROUTE_MAX_B)
    else $error("route payload exceeded");
  a_reset_note: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && cmd[mphs_pkg::CMD_SET_CONFIG] |=> reset_pend)
    else $error("set-config gave no reset notice");
endmodule

//--- mphs_pkg.sv
/*
  Package for the mesh packet header and status block: register map, fields,
  reset values, message details and tick timing.
  Assumes a 40 MHz system clock and an AHB-Lite slave with 32-bit data.
*/
package mphs_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 40000000;
  localparam int unsigned TICK_FAST_MS     = 10;
  localparam int unsigned TICK_SLOW_MS     = 2560;
  localparam int unsigned TICK_FAST_CYCLES = CLK_HZ / 1000 * TICK_FAST_MS;
  localparam int unsigned TICK_SLOW_CYCLES = CLK_HZ / 1000 * TICK_SLOW_MS;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL        = 8'h00; // Settings
  localparam logic [7:0] OFS_THRESH      = 8'h04; // Admission threshold, report interval
  localparam logic [7:0] OFS_NEXT_RX     = 8'h08; // Preferred next receiver id
  localparam logic [7:0] OFS_NET_TAG     = 8'h0c; // Gateway network tag
  localparam logic [7:0] OFS_CMD         = 8'h10; // Command and event strobes (write)
  localparam logic [7:0] OFS_LINK        = 8'h14; // Link request / status
  localparam logic [7:0] OFS_BEACON      = 8'h18; // Beacon observation in / nearest out
  localparam logic [7:0] OFS_HDR_SEQ     = 8'h1c; // Sequence number, timer
  localparam logic [7:0] OFS_FWD         = 8'h20; // Forward hop in / out
  localparam logic [7:0] OFS_SERIAL      = 8'h24; // Segment index
  localparam logic [7:0] OFS_REPORT      = 8'h28; // Last event: detail, address
  localparam logic [7:0] OFS_REPORT_ADDR = 8'h2c;
  localparam logic [7:0] OFS_STATUS      = 8'h30;
  localparam logic [7:0] OFS_ROUTE       = 8'h34; // Route trace hop append / state
  // ----------------------------------------------------------------
  // CTRL fields
  // ----------------------------------------------------------------
  localparam int CTRL_TICK_SEL   = 0;  // Delay timer tick select
  localparam int CTRL_GATEWAY    = 1;
  localparam int CTRL_BEACON_EN  = 2;
  localparam int CTRL_BUSY_CHECK = 3;
  localparam int CTRL_BUSY_HOLD  = 4;
  localparam int CTRL_ENCRYPTED  = 5;
  localparam int CTRL_ADDR_SEL   = 8;  // 3-bit report address content select
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // CMD bits
  // ----------------------------------------------------------------
  localparam int CMD_GET_STATUS  = 0;
  localparam int CMD_NEXT_RX_Q   = 1;
  localparam int CMD_TAG_Q       = 2;
  localparam int CMD_CFG_DUMP    = 3;
  localparam int CMD_FORCE_RESET = 4;
  localparam int CMD_SET_CONFIG  = 5;
  localparam int CMD_NEW_PACKET  = 6;
  localparam int CMD_DELIVER     = 7;
  localparam int CMD_SER_TIMEOUT = 8;
  localparam int CMD_SER_STREAM  = 9;
  localparam int CMD_SER_LAST    = 10;
  localparam int CMD_ROUTE_START = 11;
  localparam int CMD_ACTIVITY    = 12;
  localparam int CMD_FORM_MESH   = 13;
  // ----------------------------------------------------------------
  // Message details and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] DET_RESET      = 8'h01;
  localparam logic [7:0] DET_STATUS     = 8'h02;
  localparam logic [7:0] DET_NEXT_RX    = 8'h13;
  localparam logic [7:0] DET_NET_TAG    = 8'h12;
  localparam logic [7:0] DET_ROUTE      = 8'h20;
  localparam logic [7:0] DET_CFG_DUMP   = 8'h22;
  localparam logic [7:0] CFG_DUMP_BYTES = 8'd120;
  localparam logic [7:0] ROUTE_ENTRY_B  = 8'd5;
  localparam logic [7:0] ROUTE_MAX_B    = 8'd120;
  localparam logic [7:0] SEG_MAX        = 8'hff;
  localparam logic [7:0] SEG_BYTE_POS   = 8'd18;
  localparam logic [2:0] ADDR_SEL_BEACON = 3'h2;
  localparam logic [2:0] ADDR_SEL_NEXT   = 3'h3;
endpackage

//--- mphs_host_model.sv
/*
  Host-side model for the mesh packet header block: logs each event message
  that the block issues toward the radio side.
  Assumes event_valid is a one-cycle pulse sampled on the rising clock edge.
*/
`timescale 1ns/1ps
module mphs_host_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Event strobe from the block
  input  wire logic        event_valid,
  input  wire logic [7:0]  event_detail,
  // What the host has seen
  output logic      [15:0] ev_cnt,
  output logic      [7:0]  ev_last
);
  // One pulse is one message, so a stuck strobe shows up as extra counts
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ev_cnt  <= 16'h0000;
      ev_last <= 8'h00;
    end else if (event_valid) begin
      ev_cnt  <= ev_cnt + 16'h0001;
      ev_last <= event_detail;
    end
  end
endmodule

//--- mphs_top_tb_top.sv
/*
  Self-checking bench for the mesh packet header block, one task a scenario.
  Assumes short tick parameters (4 and 8 cycles) and a zero-wait AHB-Lite slave.
*/
`timescale 1ns/1ps
module mphs_top_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        rstn    = 1'b0;
  logic        clk_en  = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata, v;
  logic        hreadyout, hresp, event_valid;
  logic [7:0]  event_detail, ev_last;
  logic [15:0] ev_cnt;
  int          error_cnt  = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  // Short ticks keep the delay timer and interval tests within a few hundred cycles
  mphs_top #(.TICK_FAST(4), .TICK_SLOW(8)) mphs_top_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .event_valid(event_valid), .event_detail(event_detail));
  mphs_host_model mphs_host_model_inst (.clk_sys(clk_sys), .rstn(rstn), .event_valid(event_valid),
    .event_detail(event_detail), .ev_cnt(ev_cnt), .ev_last(ev_last));
  // Clock at 40 MHz
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Hang guard: the whole run needs under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // One AHB-Lite single transfer; request held until hready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("response", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0, v);
    chk(n, v, e);
  endtask
  // Command strobe, then the event count and detail the host should see
  task automatic cmd(input int b, input logic [7:0] det, input logic [15:0] dn);
    logic [15:0] c0 = ev_cnt;
    wr(mphs_pkg::OFS_CMD, 32'h1 << b);
    repeat (3) @(posedge clk_sys);
    chk("event count", {16'h0, ev_cnt}, {16'h0, c0 + dn});
    if (dn != 16'h0) chk("event detail", {24'h0, ev_last}, {24'h0, det});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("power-on notice", {16'h0, ev_cnt, ev_last}, 32'h0000_0101);
    rc(mphs_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    rc(mphs_pkg::OFS_HDR_SEQ, 32'h0, "seq reset");
    rc(8'h40, 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_events();
    cmd(mphs_pkg::CMD_GET_STATUS, mphs_pkg::DET_STATUS, 16'h1);
    wr(mphs_pkg::OFS_NEXT_RX, 32'h00a1b2c3);
    cmd(mphs_pkg::CMD_NEXT_RX_Q, mphs_pkg::DET_NEXT_RX, 16'h1);
    rc(mphs_pkg::OFS_REPORT_ADDR, 32'h00a1b2c3, "next rx addr");
    wr(mphs_pkg::OFS_NET_TAG, 32'h11223344);
    cmd(mphs_pkg::CMD_TAG_Q, 8'h00, 16'h0);
    wr(mphs_pkg::OFS_CTRL, 32'h2);
    cmd(mphs_pkg::CMD_TAG_Q, mphs_pkg::DET_NET_TAG, 16'h1);
    rc(mphs_pkg::OFS_REPORT_ADDR, 32'h11223344, "tag addr");
    cmd(mphs_pkg::CMD_CFG_DUMP, mphs_pkg::DET_CFG_DUMP, 16'h1);
    rc(mphs_pkg::OFS_REPORT_ADDR, 32'd120, "dump length");
    cmd(mphs_pkg::CMD_FORCE_RESET, mphs_pkg::DET_RESET, 16'h1);
    cmd(mphs_pkg::CMD_SET_CONFIG, mphs_pkg::DET_RESET, 16'h1);
    wr(mphs_pkg::OFS_CTRL, 32'h0);
    $display("test events done");
  endtask
  // Admission at the host's 190 limit, then interval reports of 2 fast ticks
  task automatic t_link();
    logic [15:0] c0;
    wr(mphs_pkg::OFS_THRESH, 32'hbe);
    for (int i = 0; i < 3; i++) begin
      wr(mphs_pkg::OFS_LINK, 32'hbd + i);
      xfer(1'b0, mphs_pkg::OFS_LINK, 32'h0, v);
      chk("link ok", {31'h0, v[0]}, {31'h0, i < 2});
    end
    c0 = ev_cnt;
    wr(mphs_pkg::OFS_THRESH, 32'h02be);
    repeat (40) @(posedge clk_sys);
    wr(mphs_pkg::OFS_THRESH, 32'hbe);
    chk("interval reports", {31'h0, (ev_cnt - c0) inside {[3:6]}}, 32'h1);
    chk("interval detail", {24'h0, ev_last}, {24'h0, mphs_pkg::DET_STATUS});
    $display("test link done");
  endtask
  // Delay timer over 40 cycles per tick select, frozen after delivery
  task automatic t_hdr(input logic sel, input int lo, input int hi);
    logic [31:0] s0;
    wr(mphs_pkg::OFS_CTRL, {31'h0, sel});
    xfer(1'b0, mphs_pkg::OFS_HDR_SEQ, 32'h0, s0);
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_NEW_PACKET);
    repeat (40) @(posedge clk_sys);
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_DELIVER);
    xfer(1'b0, mphs_pkg::OFS_HDR_SEQ, 32'h0, v);
    chk("seq step", {16'h0, v[15:0]}, {16'h0, s0[15:0] + 16'h1});
    chk("timer window", {31'h0, int'(v[31:16]) inside {[lo:hi]}}, 32'h1);
    repeat (20) @(posedge clk_sys);
    rc(mphs_pkg::OFS_HDR_SEQ, v, "timer frozen");
    wr(mphs_pkg::OFS_FWD, 32'h5);
    rc(mphs_pkg::OFS_FWD, 32'h6, "hop plus one");
    $display("test header done");
  endtask
  task automatic t_serial();
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_SER_TIMEOUT);
    rc(mphs_pkg::OFS_SERIAL, 32'h1200, "single block");
    for (int i = 0; i < 256; i++) wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_SER_STREAM);
    rc(mphs_pkg::OFS_SERIAL, 32'h1201, "segment wrap");
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_SER_LAST);
    rc(mphs_pkg::OFS_SERIAL, 32'h1200, "stream end");
    $display("test serial done");
  endtask
  task automatic t_beacon_route();
    wr(mphs_pkg::OFS_CTRL, 32'h200);
    wr(mphs_pkg::OFS_BEACON, 32'h500000a1);
    wr(mphs_pkg::OFS_BEACON, 32'h300000b2);
    wr(mphs_pkg::OFS_BEACON, 32'h400000c3);
    rc(mphs_pkg::OFS_BEACON, 32'hb2, "nearest beacon");
    cmd(mphs_pkg::CMD_GET_STATUS, mphs_pkg::DET_STATUS, 16'h1);
    rc(mphs_pkg::OFS_REPORT_ADDR, 32'hb2, "beacon in report");
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_ROUTE_START);
    repeat (25) wr(mphs_pkg::OFS_ROUTE, 32'h0);
    rc(mphs_pkg::OFS_ROUTE, 32'd120, "route bytes");
    xfer(1'b0, mphs_pkg::OFS_STATUS, 32'h0, v);
    chk("route full and valid", {30'h0, v[4], v[0]}, 32'h3);
    wr(mphs_pkg::OFS_CTRL, 32'h20);
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_ROUTE_START);
    wr(mphs_pkg::OFS_ROUTE, 32'h0);
    xfer(1'b0, mphs_pkg::OFS_STATUS, 32'h0, v);
    chk("route valid encrypted", {31'h0, v[4]}, 32'h0);
    $display("test beacon and route done");
  endtask
  // Competing activity blocks mesh forming only while hold is set
  task automatic t_gateway();
    wr(mphs_pkg::OFS_CTRL, 32'h1a);
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_ACTIVITY);
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_FORM_MESH);
    xfer(1'b0, mphs_pkg::OFS_STATUS, 32'h0, v);
    chk("activity held off", {30'h0, v[3:2]}, 32'h2);
    wr(mphs_pkg::OFS_CTRL, 32'h0a);
    wr(mphs_pkg::OFS_CMD, 32'h1 << mphs_pkg::CMD_FORM_MESH);
    xfer(1'b0, mphs_pkg::OFS_STATUS, 32'h0, v);
    chk("mesh formed", {30'h0, v[3:2]}, 32'h3);
    $display("test gateway done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_events();
    t_link();
    t_hdr(1'b0, 9, 11);
    t_hdr(1'b1, 4, 6);
    t_serial();
    t_beacon_route();
    t_gateway();
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    results();
  end
endmodule
